// ==== hw/sfp_top.sv ====
// Operation
// - With CTS control on, raise CTS once receive free space is 17 or less.
// - After raising CTS, lower it only when free space reaches 34 bytes.
// - With RTS control on and RTS high, stop sending queued output bytes.
// - Drop a whole radio packet that does not fit the output buffer.
// - With indicator enabled, drive data-present pin low while output queued.
// - After RTS goes high at most two more characters may still leave.
// - Transparent mode queues serial input for radio, radio data to serial.
// - Transparent mode packetizes after the idle timeout with no new character.
// - A zero timeout packetizes as soon as a character arrives, once no command sequence is under way.
// - On guard, command characters, guard, first send what preceded them.
// - Packetize as soon as buffered count reaches the maximum payload.
// - No transparent mode on SPI; SPI always runs framed API operation.
// - API mode carries all serial traffic inside frames.
// - Transparent mode sends all serial input except during command mode; the code also drops the characters of a detected command sequence.
// - API mode may return a status frame for each transmission request.
// - API received-data frames carry the sender source address.
// - No hardware flow control while SPI is the active serial port.
`timescale 1ns/10ps
module sfp_top import sfp_pkg::*; #(
  parameter int RX_DEPTH = RX_DEPTH_DEF,
  parameter int TX_DEPTH = TX_DEPTH_DEF,
  parameter int MS_CYCLES = GUARD_UNIT_CYC,
  parameter int RAW = $clog2(RX_DEPTH),
  parameter int TAW = $clog2(TX_DEPTH)
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Configuration
  input wire logic cts_flow_enable_in,
  input wire logic rts_flow_enable_in,
  input wire logic data_present_indicator_config_in,
  input wire logic api_mode_in,
  input wire logic spi_active_in,
  input wire logic command_mode_in,
  input wire logic [7:0] packetization_timeout_in,
  input wire logic [RAW:0] max_packet_payload_in,
  input wire logic [15:0] guard_time_in,
  input wire logic [7:0] command_sequence_char_in,
  // Host serial side, byte level
  input wire logic ser_rx_valid_in,
  input wire logic [7:0] ser_rx_byte_in,
  input wire logic char_tick_in,
  input wire logic api_frame_end_in,
  input wire logic rts_n_in,
  output logic cts_n_out,
  output logic data_present_pin_n_out,
  output logic ser_tx_valid_out,
  output logic [7:0] ser_tx_byte_out,
  input wire logic ser_tx_ready_in,
  // Radio transmit path
  output logic rf_tx_valid_out,
  output logic [7:0] rf_tx_byte_out,
  output logic rf_tx_last_out,
  input wire logic rf_tx_ready_in,
  input wire logic rf_tx_status_valid_in,
  input wire logic [7:0] rf_tx_status_code_in,
  // Radio receive path
  input wire logic rf_rx_start_in,
  input wire logic [TAW:0] rf_rx_len_in,
  input wire logic [SRC_ADDR_BITS-1:0] rf_rx_src_in,
  input wire logic rf_rx_valid_in,
  input wire logic [7:0] rf_rx_byte_in,
  input wire logic rf_rx_last_in,
  output logic rf_rx_ready_out,
  // Command sequence seen
  output logic cmd_seq_out
);

  localparam logic [RAW:0] RX_FULL = (RAW+1)'(RX_DEPTH);
  localparam logic [TAW:0] TX_FULL = (TAW+1)'(TX_DEPTH);
  localparam logic [RAW:0] CTS_OFF = (RAW+1)'(CTS_OFF_FREE);
  localparam logic [RAW:0] CTS_ON = (RAW+1)'(CTS_ON_FREE);
  localparam logic [RAW:0] SEQ_LEN = (RAW+1)'(CMD_SEQ_LEN);
  localparam logic [TAW+1:0] HDR_LEN = (TAW+2)'(SRC_ADDR_BYTES);

  typedef struct packed {
    sfp_pk_t pk;
    logic cts_n;
    logic dp_n;
    logic [RAW-1:0] rx_wp;
    logic [RAW-1:0] rx_rp;
    logic [RAW:0] rx_cnt;
    logic [RAW:0] pend;
    logic [RAW:0] pkt_left;
    logic [RAW:0] drop_left;
    logic [7:0] idle;
    logic det_pend;
    logic end_pend;
    logic rx_rd;
    logic rx_last;
    logic rf_v;
    logic [7:0] rf_byte;
    logic rf_last;
    logic [TAW-1:0] tx_wp;
    logic [TAW-1:0] tx_rp;
    logic [TAW:0] tx_cnt;
    logic acc;
    logic [3:0] hdr;
    logic [SRC_ADDR_BITS-1:0] src;
    logic rf_rdy;
    logic st_pend;
    logic [7:0] st_code;
    logic tx_rd;
    logic sv;
    logic [7:0] sbyte;
    logic seq;
  } sfp_top_st_t;

  sfp_top_st_t q;
  sfp_top_st_t n;

  logic api;
  logic halt;
  logic rx_we;
  logic rx_re;
  logic [RAW:0] drop;
  logic tx_we;
  logic tx_re;
  logic [7:0] tx_wdata;
  logic [TAW+1:0] need;
  logic [TAW:0] tx_free;
  logic [RAW:0] rx_free;
  logic seq_valid;
  logic seq_cand;
  logic seq_det;
  logic [7:0] rx_rdata;
  logic [7:0] tx_rdata;

  // SPI forces framed operation and turns the detector off
  assign api = api_mode_in | spi_active_in;
  assign seq_valid = ser_rx_valid_in & ~api & ~command_mode_in;

  sfp_cmd_seq #(.MS_CYCLES(MS_CYCLES)) u_seq (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .byte_valid_in(seq_valid),
    .byte_in(ser_rx_byte_in),
    .command_sequence_char_in(command_sequence_char_in),
    .guard_time_in(guard_time_in),
    .cand_out(seq_cand),
    .det_out(seq_det)
  );

  sfp_mem #(.W(8), .DEPTH(RX_DEPTH)) u_rx_mem (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .we_in(rx_we),
    .waddr_in(q.rx_wp),
    .wdata_in(ser_rx_byte_in),
    .re_in(rx_re),
    .raddr_in(q.rx_rp),
    .rdata_out(rx_rdata)
  );

  sfp_mem #(.W(8), .DEPTH(TX_DEPTH)) u_tx_mem (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .we_in(tx_we),
    .waddr_in(q.tx_wp),
    .wdata_in(tx_wdata),
    .re_in(tx_re),
    .raddr_in(q.tx_rp),
    .rdata_out(tx_rdata)
  );

  always_comb begin
    n = q;
    rx_we = 1'b0;
    rx_re = 1'b0;
    drop = '0;
    tx_we = 1'b0;
    tx_re = 1'b0;
    tx_wdata = 8'h00;
    n.seq = seq_det;
    rx_free = RX_FULL - q.rx_cnt;
    tx_free = TX_FULL - q.tx_cnt;
    need = {1'b0, rf_rx_len_in} + (api ? HDR_LEN : '0);
    halt = rts_flow_enable_in & rts_n_in & ~spi_active_in;

    // Serial input; overflow bytes are lost when the host ignores CTS
    if (ser_rx_valid_in && (api || !command_mode_in)
        && q.rx_cnt != RX_FULL) begin
      rx_we = 1'b1;
      n.rx_wp = q.rx_wp + 1'b1;
    end
    if (ser_rx_valid_in) begin
      n.idle = 8'h00;
    end else if (char_tick_in && q.idle != IDLE_MAX) begin
      n.idle = q.idle + 8'h01;
    end
    // Radio output stage
    if (q.rf_v && rf_tx_ready_in) begin
      n.rf_v = 1'b0;
    end
    if (q.rx_rd) begin
      n.rf_v = 1'b1;
      n.rf_byte = rx_rdata;
      n.rf_last = q.rx_last;
      n.rx_rd = 1'b0;
    end

    unique case (q.pk)
      SFP_PK_FILL: begin
        if (api) begin
          if (q.end_pend && q.pend != '0) begin
            n.end_pend = 1'b0;
            n.pkt_left = q.pend;
            n.pend = '0;
            n.pk = SFP_PK_SEND;
          end
        end else if (q.det_pend) begin
          // Characters before the sequence go first, the sequence is dropped
          n.det_pend = 1'b0;
          if (q.pend >= SEQ_LEN) begin
            n.pkt_left = q.pend - SEQ_LEN;
            n.drop_left = SEQ_LEN;
            n.pend = '0;
            n.pk = SFP_PK_SEND;
          end
        end else if (max_packet_payload_in != '0
                     && q.pend >= max_packet_payload_in) begin
          n.pkt_left = max_packet_payload_in;
          n.pend = q.pend - max_packet_payload_in;
          n.pk = SFP_PK_SEND;
        end else if (q.pend != '0 && !seq_cand
                     && q.idle >= packetization_timeout_in) begin
          n.pkt_left = q.pend;
          n.pend = '0;
          n.pk = SFP_PK_SEND;
        end
      end
      SFP_PK_SEND: begin
        if (q.pkt_left != '0 && !q.rx_rd && (!q.rf_v || rf_tx_ready_in)) begin
          rx_re = 1'b1;
          n.rx_rp = q.rx_rp + 1'b1;
          n.pkt_left = q.pkt_left - 1'b1;
          n.rx_rd = 1'b1;
          n.rx_last = (q.pkt_left == (RAW+1)'(1));
        end else if (q.pkt_left == '0 && !q.rx_rd && !q.rf_v) begin
          n.pk = (q.drop_left != '0) ? SFP_PK_DROP : SFP_PK_FILL;
        end
      end
      SFP_PK_DROP: begin
        drop = q.drop_left;
        n.rx_rp = q.rx_rp + q.drop_left[RAW-1:0];
        n.drop_left = '0;
        n.pk = SFP_PK_FILL;
      end
    endcase
    // A new event wins over the clear of the one just taken
    if (seq_det) begin
      n.det_pend = 1'b1;
    end
    if (api && api_frame_end_in) begin
      n.end_pend = 1'b1;
    end
    if (rx_we) begin
      n.pend = n.pend + (RAW+1)'(1);
    end
    n.rx_cnt = q.rx_cnt + {{RAW{1'b0}}, rx_we} - {{RAW{1'b0}}, rx_re}
               - drop;

    // Radio packet admission is decided once, from the full length
    if (rf_rx_start_in) begin
      n.acc = (need <= {1'b0, tx_free});
      if (need <= {1'b0, tx_free} && api) begin
        n.src = rf_rx_src_in;
        n.hdr = 4'(SRC_ADDR_BYTES);
      end
    end
    if (q.hdr != 4'h0) begin
      tx_we = 1'b1;
      tx_wdata = q.src[SRC_ADDR_BITS-1 -: 8];
      n.src = {q.src[SRC_ADDR_BITS-9:0], 8'h00};
      n.hdr = q.hdr - 4'h1;
    end else if (rf_rx_valid_in && q.rf_rdy) begin
      if (q.acc && q.tx_cnt != TX_FULL) begin
        tx_we = 1'b1;
        tx_wdata = rf_rx_byte_in;
      end
      if (rf_rx_last_in) begin
        n.acc = 1'b0;
      end
    end else if (q.st_pend && !q.acc && q.tx_cnt != TX_FULL) begin
      tx_we = 1'b1;
      tx_wdata = q.st_code;
      n.st_pend = 1'b0;
    end
    // A new status wins over the write that empties the slot
    if (api && rf_tx_status_valid_in) begin
      n.st_pend = 1'b1;
      n.st_code = rf_tx_status_code_in;
    end
    if (tx_we) begin
      n.tx_wp = q.tx_wp + 1'b1;
    end
    n.rf_rdy = (n.hdr == 4'h0);

    // Serial output; the byte already fetched still leaves after RTS rises
    if (q.sv && ser_tx_ready_in) begin
      n.sv = 1'b0;
    end
    if (q.tx_rd) begin
      n.sv = 1'b1;
      n.sbyte = tx_rdata;
      n.tx_rd = 1'b0;
    end
    if (q.tx_cnt != '0 && !halt && !q.tx_rd
        && (!q.sv || ser_tx_ready_in)) begin
      tx_re = 1'b1;
      n.tx_rp = q.tx_rp + 1'b1;
      n.tx_rd = 1'b1;
    end
    n.tx_cnt = q.tx_cnt + {{TAW{1'b0}}, tx_we} - {{TAW{1'b0}}, tx_re};

    // CTS with hysteresis; no flow control on SPI
    if (!cts_flow_enable_in || spi_active_in) begin
      n.cts_n = 1'b0;
    end else if (!q.cts_n && rx_free <= CTS_OFF) begin
      n.cts_n = 1'b1;
    end else if (q.cts_n && rx_free >= CTS_ON) begin
      n.cts_n = 1'b0;
    end else begin
      n.cts_n = q.cts_n;
    end

    n.dp_n = ~(data_present_indicator_config_in
               & (n.tx_cnt != '0 | n.sv));
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '{pk: SFP_PK_FILL, dp_n: 1'b1, rf_rdy: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  assign cts_n_out = q.cts_n;
  assign data_present_pin_n_out = q.dp_n;
  assign ser_tx_valid_out = q.sv;
  assign ser_tx_byte_out = q.sbyte;
  assign rf_tx_valid_out = q.rf_v;
  assign rf_tx_byte_out = q.rf_byte;
  assign rf_tx_last_out = q.rf_last;
  assign rf_rx_ready_out = q.rf_rdy;
  assign cmd_seq_out = q.seq;

endmodule

// ==== hw/sfp_pkg.sv ====
package sfp_pkg;

  // Flow control thresholds, in free bytes of the serial receive buffer
  localparam int CTS_OFF_FREE = 17;
  localparam int CTS_ON_FREE = 34;

  // Buffer depths; powers of two so pointers wrap naturally
  localparam int RX_DEPTH_DEF = 256;
  localparam int TX_DEPTH_DEF = 256;

  // Sender address prepended to every received-data frame in API mode
  localparam int SRC_ADDR_BYTES = 8;
  localparam int SRC_ADDR_BITS = SRC_ADDR_BYTES * 8;

  // Command sequence is this many command characters between guard times
  localparam int CMD_SEQ_LEN = 3;

  // Guard time unit and clock rate
  localparam int CLK_PERIOD_NS = 100;
  localparam int GUARD_UNIT_NS = 1000000;
  localparam int GUARD_UNIT_CYC = GUARD_UNIT_NS / CLK_PERIOD_NS;

  // Saturation value of the character-time idle counter
  localparam logic [7:0] IDLE_MAX = 8'hff;

  typedef enum logic [1:0] {
    SFP_PK_FILL,
    SFP_PK_SEND,
    SFP_PK_DROP
  } sfp_pk_t;

  typedef enum logic [1:0] {
    SFP_GS_IDLE,
    SFP_GS_CHARS,
    SFP_GS_POST
  } sfp_gs_t;

endpackage

// ==== hw/sfp_mem.sv ====
`timescale 1ns/10ps
module sfp_mem #(
  parameter int W = 8,
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [W-1:0] wdata_in,
  // Read port, data one cycle after re_in
  input wire logic re_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [W-1:0] rdata_out
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] q;
  } sfp_mem_st_t;

  sfp_mem_st_t r;
  sfp_mem_st_t next_r;

  always_comb begin
    next_r = r;
    if (we_in) begin
      next_r.mem[waddr_in] = wdata_in;
    end
    if (re_in) begin
      next_r.q = r.mem[raddr_in];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rdata_out = r.q;

endmodule

// ==== hw/sfp_cmd_seq.sv ====
`timescale 1ns/10ps
module sfp_cmd_seq import sfp_pkg::*; #(
  parameter int MS_CYCLES = GUARD_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Received serial characters
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  // Settings
  input wire logic [7:0] command_sequence_char_in,
  input wire logic [15:0] guard_time_in,
  // Sequence under way, and one-cycle detection
  output logic cand_out,
  output logic det_out
);

  typedef struct packed {
    sfp_gs_t st;
    logic [31:0] ms_cnt;
    logic [15:0] idle_ms;
    logic [1:0] n;
    logic cand;
    logic det;
  } sfp_seq_st_t;

  sfp_seq_st_t r;
  sfp_seq_st_t next_r;
  logic guard_met;
  logic is_cc;

  always_comb begin
    next_r = r;
    next_r.det = 1'b0;
    guard_met = (r.idle_ms >= guard_time_in);
    is_cc = (byte_in == command_sequence_char_in);
    if (byte_valid_in) begin
      next_r.idle_ms = '0;
      next_r.ms_cnt = '0;
    end else if (r.ms_cnt == 32'(MS_CYCLES - 1)) begin
      next_r.ms_cnt = '0;
      if (r.idle_ms != 16'hffff) begin
        next_r.idle_ms = r.idle_ms + 16'h0001;
      end
    end else begin
      next_r.ms_cnt = r.ms_cnt + 32'h1;
    end
    unique case (r.st)
      SFP_GS_IDLE: begin
        if (byte_valid_in && is_cc && guard_met) begin
          next_r.st = SFP_GS_CHARS;
          next_r.n = 2'h1;
        end
      end
      SFP_GS_CHARS: begin
        // Characters of the sequence must follow within one guard time
        if (byte_valid_in) begin
          if (is_cc && !guard_met) begin
            next_r.n = r.n + 2'h1;
            if (r.n == 2'(CMD_SEQ_LEN - 1)) begin
              next_r.st = SFP_GS_POST;
            end
          end else begin
            next_r.st = SFP_GS_IDLE;
          end
        end else if (guard_met) begin
          next_r.st = SFP_GS_IDLE;
        end
      end
      SFP_GS_POST: begin
        if (byte_valid_in) begin
          next_r.st = SFP_GS_IDLE;
        end else if (guard_met) begin
          next_r.st = SFP_GS_IDLE;
          next_r.det = 1'b1;
        end
      end
      default: begin
        next_r.st = SFP_GS_IDLE;
      end
    endcase
    next_r.cand = (next_r.st != SFP_GS_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '{st: SFP_GS_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign cand_out = r.cand;
  assign det_out = r.det;

endmodule

// ==== bench/sfp_checker.sv ====
`timescale 1ns/10ps
module sfp_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Settings
  input wire logic cts_flow_enable_in,
  input wire logic rts_flow_enable_in,
  input wire logic data_present_indicator_config_in,
  input wire logic spi_active_in,
  // Host side
  input wire logic ser_rx_valid_in,
  input wire logic rts_n_in,
  input wire logic cts_n_out,
  input wire logic data_present_pin_n_out,
  input wire logic ser_tx_valid_out,
  input wire logic [7:0] ser_tx_byte_out,
  input wire logic ser_tx_ready_in,
  // Radio side, and command sequence seen
  input wire logic rf_tx_valid_out,
  input wire logic [7:0] rf_tx_byte_out,
  input wire logic rf_tx_last_out,
  input wire logic rf_tx_ready_in,
  input wire logic rf_rx_ready_out,
  input wire logic cmd_seq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Bytes that still left after the host asked to stop
  logic [3:0] sent;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      sent <= 4'h0;
    else if (!(rts_flow_enable_in && rts_n_in && !spi_active_in))
      sent <= 4'h0;
    else if (ser_tx_valid_out && ser_tx_ready_in && sent < 4'hf)
      sent <= sent + 4'h1;
  end

  sequence hdr_gap;
    !rf_rx_ready_out[*8] ##1 rf_rx_ready_out;
  endsequence

  a_cts_off_disabled: assert property (
    (!cts_flow_enable_in || spi_active_in) |=> !cts_n_out)
    else $error("cts raised while flow control off");
  a_cts_rise_cause: assert property (
    $rose(cts_n_out) && $past(cts_flow_enable_in, 2) &&
    !$past(spi_active_in, 2) |-> $past(ser_rx_valid_in, 2))
    else $error("cts raised without incoming byte");
  a_tx_byte_hold: assert property (
    ser_tx_valid_out && !ser_tx_ready_in |=>
    ser_tx_valid_out && $stable(ser_tx_byte_out))
    else $error("serial byte not held");
  a_rf_byte_hold: assert property (
    rf_tx_valid_out && !rf_tx_ready_in |=> rf_tx_valid_out &&
    $stable(rf_tx_byte_out) && $stable(rf_tx_last_out))
    else $error("radio byte not held");
  a_rts_stop_count: assert property (sent <= 4'h2)
    else $error("too many bytes after rts stop");
  a_seq_one_pulse: assert property (cmd_seq_out |=> !cmd_seq_out)
    else $error("sequence pulse too long");
  a_hdr_gap_len: assert property ($fell(rf_rx_ready_out) |-> hdr_gap)
    else $error("address header gap wrong");
  a_dp_queued: assert property (
    $past(data_present_indicator_config_in) && $past(ser_tx_valid_out) &&
    ser_tx_valid_out |-> !data_present_pin_n_out)
    else $error("data present pin high with byte held");
endmodule

bind sfp_top sfp_checker sfp_checker_i (.*);

// ==== bench/sfp_host.sv ====
`timescale 1ns/10ps
module sfp_host (
  // Clock
  input wire logic clk_in,
  // Behaviour select from the bench
  input wire logic slow_in,
  input wire logic hold_in,
  // Serial output of the device
  input wire logic ser_tx_valid_out,
  input wire logic [7:0] ser_tx_byte_out,
  output logic ser_tx_ready_in,
  output logic rts_n_in
);
  logic [7:0] got[$];
  logic ph;
  initial begin
    ser_tx_ready_in = 1'b0;
    rts_n_in = 1'b0;
    ph = 1'b0;
  end
  // Takes any byte offered, also those after RTS went high
  always @(posedge clk_in) begin
    if (ser_tx_valid_out === 1'b1 && ser_tx_ready_in)
      got.push_back(ser_tx_byte_out);
    ph <= ~ph;
    // Slow host accepts only every other cycle
    ser_tx_ready_in <= #1 !(slow_in && ph);
    // Stop is only held briefly by the bench
    rts_n_in <= #1 hold_in;
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb import sfp_pkg::*; ;
  typedef struct {logic spi; logic api; logic cmd; logic fe; int n;} sfp_row_t;
  logic clk_in, rst_n_in, cts_flow_enable_in, rts_flow_enable_in;
  logic data_present_indicator_config_in, api_mode_in, spi_active_in;
  logic command_mode_in, ser_rx_valid_in, char_tick_in, api_frame_end_in;
  logic rts_n_in, cts_n_out, data_present_pin_n_out, ser_tx_valid_out;
  logic ser_tx_ready_in, rf_tx_valid_out, rf_tx_last_out, rf_tx_ready_in;
  logic rf_tx_status_valid_in, rf_rx_start_in, rf_rx_valid_in;
  logic rf_rx_last_in, rf_rx_ready_out, cmd_seq_out, slow_in, hold_in, cts_q;
  logic [7:0] packetization_timeout_in, command_sequence_char_in;
  logic [7:0] ser_rx_byte_in, ser_tx_byte_out, rf_tx_byte_out;
  logic [7:0] rf_tx_status_code_in, rf_rx_byte_in;
  logic [8:0] max_packet_payload_in, rf_rx_len_in;
  logic [15:0] guard_time_in;
  logic [63:0] rf_rx_src_in;
  logic [7:0] rfq[$];
  logic lq[$];
  int mismatches, comparisons, seqs, fall_at, i;
  sfp_row_t rows[4] = '{'{0, 0, 0, 0, 1}, '{0, 0, 1, 0, 0},
                        '{0, 1, 0, 1, 1}, '{1, 0, 1, 1, 1}};

  sfp_top #(.MS_CYCLES(4)) sfp_top_i (.*);
  sfp_host sfp_host_i (.*);

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (rf_tx_valid_out === 1'b1 && rf_tx_ready_in) begin
      rfq.push_back(rf_tx_byte_out);
      lq.push_back(rf_tx_last_out);
    end
    if (cmd_seq_out === 1'b1)
      seqs++;
    if (cts_q === 1'b1 && cts_n_out === 1'b0)
      fall_at = rfq.size();
    cts_q <= cts_n_out;
  end

  task automatic chk(input logic c, input string m);
    comparisons++;
    if (c !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Two cycles per byte so valid never rises in the time step it fell
  task automatic send(input logic [7:0] b);
    ser_rx_valid_in = 1'b1;
    ser_rx_byte_in = b;
    tick(1);
    ser_rx_valid_in = 1'b0;
    tick(1);
  endtask

  task automatic chars(input int n);
    repeat (n) begin
      char_tick_in = 1'b1;
      tick(1);
      char_tick_in = 1'b0;
      tick(1);
    end
  endtask

  task automatic frame_end;
    api_frame_end_in = 1'b1;
    tick(1);
    api_frame_end_in = 1'b0;
  endtask

  task automatic rfin(input logic [8:0] len, input logic [63:0] src);
    rf_rx_start_in = 1'b1;
    rf_rx_len_in = len;
    rf_rx_src_in = src;
    tick(1);
    rf_rx_start_in = 1'b0;
    for (int k = 0; k < len; k++) begin
      rf_rx_valid_in = 1'b1;
      rf_rx_byte_in = k[7:0];
      rf_rx_last_in = (k == len - 1);
      do @(posedge clk_in); while (rf_rx_ready_out !== 1'b1);
      #1;
    end
    rf_rx_valid_in = 1'b0;
    rf_rx_last_in = 1'b0;
  endtask

  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end

  initial begin
    {rst_n_in, spi_active_in, api_mode_in, command_mode_in} = 4'h0;
    {cts_flow_enable_in, rts_flow_enable_in} = 2'h3;
    data_present_indicator_config_in = 1'b1;
    {ser_rx_valid_in, char_tick_in, api_frame_end_in, slow_in} = 4'h0;
    {hold_in, rf_tx_status_valid_in, rf_rx_start_in} = 3'h0;
    {rf_rx_valid_in, rf_rx_last_in, cts_q} = 3'h0;
    rf_tx_ready_in = 1'b1;
    {packetization_timeout_in, ser_rx_byte_in, rf_rx_byte_in} = 24'h0;
    command_sequence_char_in = 8'h2b;
    rf_tx_status_code_in = 8'h5a;
    {max_packet_payload_in, rf_rx_len_in} = 18'h0;
    guard_time_in = 16'h0002;
    rf_rx_src_in = 64'h0;
    tick(5);
    chk(cts_n_out === 1'b0 && data_present_pin_n_out === 1'b1 &&
        rf_rx_ready_out === 1'b1 && ser_tx_valid_out === 1'b0 &&
        rf_tx_valid_out === 1'b0 && cmd_seq_out === 1'b0, "reset values");
    rst_n_in = 1'b1;
    tick(1);
    foreach (rows[r]) begin
      {spi_active_in, api_mode_in} = {rows[r].spi, rows[r].api};
      command_mode_in = rows[r].cmd;
      tick(2);
      send(8'h40 + r[7:0]);
      if (rows[r].fe)
        frame_end();
      tick(20);
      chk(rfq.size() == rows[r].n, "row byte count");
      if (rows[r].n == 1)
        chk(rfq[0] === 8'h40 + r[7:0] && lq[0] === 1'b1, "row byte");
      rfq.delete();
      lq.delete();
    end
    {spi_active_in, api_mode_in, command_mode_in} = 3'h0;
    // Radio stalls while the packet fills
    packetization_timeout_in = 8'h05;
    max_packet_payload_in = 9'h004;
    rf_tx_ready_in = 1'b0;
    for (i = 0; i < 5; i++)
      send(i[7:0]);
    tick(10);
    rf_tx_ready_in = 1'b1;
    tick(20);
    chk(rfq.size() == 4 && lq[3] === 1'b1 && lq[2] === 1'b0, "fill");
    max_packet_payload_in = 9'h000;
    chars(4);
    chk(rfq.size() == 4, "idle too early");
    chars(1);
    tick(20);
    chk(rfq.size() == 5 && rfq[4] === 8'h04 && lq[4] === 1'b1, "idle");
    rfq.delete();
    lq.delete();
    send(8'h41);
    send(8'h42);
    tick(20);
    repeat (3) send(8'h2b);
    tick(20);
    chk(seqs == 1 && rfq.size() == 2 && rfq[1] === 8'h42, "sequence");
    rfq.delete();
    lq.delete();
    api_mode_in = 1'b1;
    for (i = 0; i < RX_DEPTH_DEF - CTS_OFF_FREE - 1; i++)
      send(i[7:0]);
    chk(cts_n_out === 1'b0, "cts early");
    send(8'hee);
    chk(cts_n_out === 1'b1, "cts not raised");
    cts_flow_enable_in = 1'b0;
    tick(2);
    chk(cts_n_out === 1'b0, "cts with control off");
    {cts_flow_enable_in, spi_active_in} = 2'h3;
    tick(2);
    chk(cts_n_out === 1'b0, "cts on spi");
    spi_active_in = 1'b0;
    tick(2);
    chk(cts_n_out === 1'b1, "cts level");
    fall_at = -1;
    frame_end();
    tick(700);
    chk(fall_at >= 14 && fall_at <= 18, "cts release point");
    chk(rfq.size() == 239 && rfq[238] === 8'hee, "drain");
    hold_in = 1'b1;
    tick(2);
    rfin(9'h002, 64'h0102030405060708);
    tick(20);
    chk(sfp_host_i.got.size() == 0, "sent while rts high");
    chk(data_present_pin_n_out === 1'b0, "data present");
    {slow_in, hold_in} = 2'h2;
    rf_tx_status_valid_in = 1'b1;
    tick(1);
    rf_tx_status_valid_in = 1'b0;
    tick(60);
    for (i = 0; i < 8; i++)
      chk(sfp_host_i.got[i] === i[7:0] + 8'h01, "source byte");
    chk(sfp_host_i.got[9] === 8'h01, "payload");
    chk(sfp_host_i.got[10] === 8'h5a, "status byte");
    chk(data_present_pin_n_out === 1'b1, "data present idle");
    rfin(9'h0f9, 64'h0);
    tick(20);
    chk(sfp_host_i.got.size() == 11, "oversize kept");
    rfin(9'h0f8, 64'h0);
    // Stop the host in mid output: fetched and held bytes may still leave
    hold_in = 1'b1;
    tick(1);
    i = sfp_host_i.got.size();
    tick(30);
    chk(sfp_host_i.got.size() <= i + 2, "too many after rts stop");
    i = sfp_host_i.got.size();
    tick(30);
    chk(sfp_host_i.got.size() == i, "output during rts stop");
    hold_in = 1'b0;
    tick(700);
    chk(sfp_host_i.got.size() == 267, "exact fit lost");
    complete_run();
  end
endmodule
